// file: verilog/scrf_params.svh
// constants for the receive-full flag block
`ifndef SCRF_PARAMS_SVH
`define SCRF_PARAMS_SVH
`define SCRF_ADDR_W        4
`define SCRF_OFS_CTRL      4'h0
`define SCRF_OFS_STATUS    4'h4
`define SCRF_OFS_HOLD      4'h8
`define SCRF_CTRL_RXEN_BIT 0
`define SCRF_CTRL_TYPE_BIT 1
`define SCRF_STAT_FULL_BIT 6
`define SCRF_FULL_RST      1'h0
`define SCRF_CTRL_RST      2'h0
`define SCRF_HOLD_RST      8'h00
`endif

// file: verilog/scrf_pkg.sv
// types shared by the receive-full flag block
package scrf_pkg;
  typedef enum logic {
    SCRF_CHAR  = 1'b0,
    SCRF_BLOCK = 1'b1
  } scrf_proto_t;

  typedef struct packed {
    logic       done;
    logic       perr;
    logic [7:0] data;
  } scrf_rx_t;

  typedef struct packed {
    logic        rxen;
    scrf_proto_t proto;
  } scrf_ctrl_t;
endpackage

// file: verilog/scrf_xfer.sv
// decides whether a finished reception moves into the holding register
`timescale 1ns/100ps
`include "scrf_params.svh"
module scrf_xfer (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire scrf_pkg::scrf_rx_t   rx,
  input  wire scrf_pkg::scrf_ctrl_t ctrl,
  output logic                      load,
  output logic [7:0]                hold_data
);
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;

  always_comb begin
    // character protocol drops parity-failed bytes; block keeps them
    load = rx.done && ctrl.rxen // see (RL7)
           && (!rx.perr // see (RL5)
               || ctrl.proto == scrf_pkg::SCRF_BLOCK); // see (RL6)
    hold_nxt = load ? rx.data : hold_r; // see (RL4)
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hold_r <= `SCRF_HOLD_RST;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  assign hold_data = hold_r;

  chk_char_perr_drop: assert property (@(posedge sys_clk) // see (RL5)
    disable iff (srst)
    rx.done && rx.perr && ctrl.proto == scrf_pkg::SCRF_CHAR
    |=> $stable(hold_r))
    else $error("holding changed on char parity error");
  chk_rxoff_hold: assert property (@(posedge sys_clk) // see (RL7)
    disable iff (srst)
    !ctrl.rxen |=> $stable(hold_r))
    else $error("holding changed with receiver off");
  chk_block_perr_load: assert property (@(posedge sys_clk) // see (RL6)
    disable iff (srst)
    rx.done && rx.perr && ctrl.rxen && ctrl.proto == scrf_pkg::SCRF_BLOCK
    |=> hold_r == $past(rx.data))
    else $error("block parity byte not loaded");
endmodule // scrf_xfer

// file: verilog/scrf_top.sv
// receive-full flag, holding register and control bits behind a plain port
//
// Contract
// (RL1) reset clears the receive-full flag.
// (RL2) reading the holding register clears the flag.
// (RL3) writing 0 to the flag bit clears it.
// (RL4) good reception loads the holding register and sets the flag.
// (RL5) character protocol: parity error leaves holding and flag alone.
// (RL6) block protocol: parity error still loads and sets the flag.
// (RL7) receiver disabled: holding and flag stay unchanged.
// (RL8) writing 1 to the flag bit has no effect.
`timescale 1ns/100ps
`include "scrf_params.svh"
module scrf_top (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic [`SCRF_ADDR_W-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic [31:0]                  rdata,
  input  wire logic                    rx_done,
  input  wire logic                    rx_perr,
  input  wire logic [7:0]              rx_data,
  output logic                         receive_full_flag,
  output logic [7:0]                   receive_holding_register
);
  ////////////////////////////////////////////////////////////////////////////
  scrf_pkg::scrf_ctrl_t ctrl_r;
  scrf_pkg::scrf_ctrl_t ctrl_nxt;
  scrf_pkg::scrf_rx_t   rx;
  logic                 full_r;
  logic                 full_nxt;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;
  logic                 load;
  logic [7:0]           hold_data;

  function automatic logic hit(input logic [`SCRF_ADDR_W-1:0] a,
                               input logic [`SCRF_ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  assign rx = '{done: rx_done, perr: rx_perr, data: rx_data};

  scrf_xfer u_xfer (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .rx        (rx),
    .ctrl      (ctrl_r),
    .load      (load),
    .hold_data (hold_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr && hit(addr, `SCRF_OFS_CTRL)) begin
      ctrl_nxt.rxen  = wdata[`SCRF_CTRL_RXEN_BIT];
      ctrl_nxt.proto = scrf_pkg::scrf_proto_t'(wdata[`SCRF_CTRL_TYPE_BIT]);
    end
  end

  always_comb begin
    full_nxt = full_r;
    if (rd && hit(addr, `SCRF_OFS_HOLD)) begin
      full_nxt = 1'b0; // see (RL2)
    end
    // only a 0 clears; a 1 written is ignored
    if (wr && hit(addr, `SCRF_OFS_STATUS) &&
        !wdata[`SCRF_STAT_FULL_BIT]) begin
      full_nxt = 1'b0; // see (RL3) (RL8)
    end
    // set beats a clear in the same cycle so no byte is lost
    if (load) begin
      full_nxt = 1'b1; // see (RL4) (RL6)
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd) begin
      if (hit(addr, `SCRF_OFS_CTRL)) begin
        rdata_nxt[`SCRF_CTRL_RXEN_BIT] = ctrl_r.rxen;
        rdata_nxt[`SCRF_CTRL_TYPE_BIT] = ctrl_r.proto;
      end else if (hit(addr, `SCRF_OFS_STATUS)) begin
        rdata_nxt[`SCRF_STAT_FULL_BIT] = full_r;
      end else if (hit(addr, `SCRF_OFS_HOLD)) begin
        rdata_nxt[7:0] = hold_data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r  <= `SCRF_CTRL_RST;
      full_r  <= `SCRF_FULL_RST; // see (RL1)
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      full_r  <= full_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata                    = rdata_r;
  assign receive_full_flag        = full_r;
  assign receive_holding_register = hold_data;

  ////////////////////////////////////////////////////////////////////////////
  // the bench keeps reads, writes and receptions apart; these also guard
  // the overlaps that it never drives
  chk_reset_clear: assert property (@(posedge sys_clk) // see (RL1)
    srst |=> !full_r)
    else $error("flag not cleared by reset");
  chk_read_clear: assert property (@(posedge sys_clk) // see (RL2)
    disable iff (srst)
    rd && hit(addr, `SCRF_OFS_HOLD) && !load |=> !full_r)
    else $error("read did not clear flag");
  chk_write0_clear: assert property (@(posedge sys_clk) // see (RL3)
    disable iff (srst)
    wr && hit(addr, `SCRF_OFS_STATUS) && !wdata[`SCRF_STAT_FULL_BIT]
    && !load |=> !full_r)
    else $error("write 0 did not clear flag");
  chk_load_set: assert property (@(posedge sys_clk) // see (RL4)
    disable iff (srst)
    rx_done && !rx_perr && ctrl_r.rxen |=> full_r
    && receive_holding_register == $past(rx_data))
    else $error("good byte not loaded");
  chk_no_stray_set: assert property (@(posedge sys_clk) // see (RL4)
    disable iff (srst)
    !full_r && !load |=> !full_r)
    else $error("flag set without a load");
  chk_hold_steady: assert property (@(posedge sys_clk) // see (RL4)
    disable iff (srst)
    !load |=> $stable(receive_holding_register))
    else $error("holding changed without a load");
  chk_load_wins: assert property (@(posedge sys_clk) // see (RL4)
    disable iff (srst)
    load |=> full_r)
    else $error("clear beat a load");
  chk_char_perr_flag: assert property (@(posedge sys_clk) // see (RL5)
    disable iff (srst)
    rx_done && rx_perr && ctrl_r.proto == scrf_pkg::SCRF_CHAR && full_r
    && !rd && !wr |=> full_r)
    else $error("flag disturbed on char parity");
  chk_char_perr_noset: assert property (@(posedge sys_clk) // see (RL5)
    disable iff (srst)
    rx_done && rx_perr && ctrl_r.proto == scrf_pkg::SCRF_CHAR && !full_r
    |=> !full_r)
    else $error("flag set on char parity");
  chk_char_perr_noload: assert property (@(posedge sys_clk) // see (RL5)
    disable iff (srst)
    rx_done && rx_perr && ctrl_r.proto == scrf_pkg::SCRF_CHAR |-> !load)
    else $error("char parity byte accepted");
  chk_block_perr_set: assert property (@(posedge sys_clk) // see (RL6)
    disable iff (srst)
    rx_done && rx_perr && ctrl_r.rxen
    && ctrl_r.proto == scrf_pkg::SCRF_BLOCK |=> full_r)
    else $error("flag not set on block parity");
  chk_rxoff_flag: assert property (@(posedge sys_clk) // see (RL7)
    disable iff (srst)
    !ctrl_r.rxen && !full_r |=> !full_r)
    else $error("flag set with receiver off");
  chk_rxoff_keep: assert property (@(posedge sys_clk) // see (RL7)
    disable iff (srst)
    !ctrl_r.rxen && full_r && !rd && !wr |=> full_r)
    else $error("flag lost with receiver off");
  chk_rxoff_noload: assert property (@(posedge sys_clk) // see (RL7)
    disable iff (srst)
    !ctrl_r.rxen |-> !load)
    else $error("byte accepted with receiver off");
  chk_write1_keep: assert property (@(posedge sys_clk) // see (RL8)
    disable iff (srst)
    wr && hit(addr, `SCRF_OFS_STATUS) && wdata[`SCRF_STAT_FULL_BIT]
    && !full_r && !load |=> !full_r)
    else $error("write 1 set the flag");
  chk_flag_keep: assert property (@(posedge sys_clk) // see (RL8)
    disable iff (srst)
    full_r && !(rd && hit(addr, `SCRF_OFS_HOLD))
    && !(wr && hit(addr, `SCRF_OFS_STATUS) && !wdata[`SCRF_STAT_FULL_BIT])
    |=> full_r)
    else $error("flag cleared without a clear");

  ////////////////////////////////////////////////////////////////////////////
  chk_read_data: assert property (@(posedge sys_clk)
    disable iff (srst)
    rd && hit(addr, `SCRF_OFS_STATUS) |=> rdata[`SCRF_STAT_FULL_BIT]
    == $past(full_r))
    else $error("status read mismatch");
  chk_status_bits: assert property (@(posedge sys_clk)
    disable iff (srst)
    rd && hit(addr, `SCRF_OFS_STATUS) |=> (rdata
    & ~(32'h0000_0001 << `SCRF_STAT_FULL_BIT)) == 32'h0000_0000)
    else $error("status read shows stray bits");
  chk_hold_read: assert property (@(posedge sys_clk)
    disable iff (srst)
    rd && hit(addr, `SCRF_OFS_HOLD)
    |=> rdata == {24'h00_0000, $past(receive_holding_register)})
    else $error("holding read mismatch");
  chk_ctrl_read: assert property (@(posedge sys_clk)
    disable iff (srst)
    rd && hit(addr, `SCRF_OFS_CTRL) |=> rdata[`SCRF_CTRL_RXEN_BIT]
    == $past(ctrl_r.rxen) && rdata[`SCRF_CTRL_TYPE_BIT] == $past(ctrl_r.proto))
    else $error("control read mismatch");
  chk_ctrl_write: assert property (@(posedge sys_clk)
    disable iff (srst)
    wr && hit(addr, `SCRF_OFS_CTRL) |=> ctrl_r.rxen == $past(wdata[0])
    && ctrl_r.proto == $past(wdata[`SCRF_CTRL_TYPE_BIT]))
    else $error("control write not taken");
  chk_ctrl_keep: assert property (@(posedge sys_clk)
    disable iff (srst)
    !(wr && hit(addr, `SCRF_OFS_CTRL)) |=> $stable(ctrl_r))
    else $error("control changed without a write");
  chk_unmapped_read: assert property (@(posedge sys_clk)
    disable iff (srst)
    rd && !hit(addr, `SCRF_OFS_CTRL) && !hit(addr, `SCRF_OFS_STATUS)
    && !hit(addr, `SCRF_OFS_HOLD) |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_rdata_idle: assert property (@(posedge sys_clk)
    disable iff (srst)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data outside its slot");

  cov_good_byte: cover property (@(posedge sys_clk) disable iff (srst)
    load && !rx_perr ##1 rd && hit(addr, `SCRF_OFS_HOLD));
  cov_block_perr: cover property (@(posedge sys_clk) disable iff (srst)
    load && rx_perr);
  cov_set_vs_clr: cover property (@(posedge sys_clk) disable iff (srst)
    load && rd && hit(addr, `SCRF_OFS_HOLD));
  cov_write0_clear: cover property (@(posedge sys_clk) disable iff (srst)
    full_r && wr && hit(addr, `SCRF_OFS_STATUS)
    && !wdata[`SCRF_STAT_FULL_BIT]);
  cov_rxoff_drop: cover property (@(posedge sys_clk) disable iff (srst)
    rx_done && !ctrl_r.rxen && full_r);
endmodule // scrf_top

// file: sim/scrf_card_model.sv
// card side model: hands finished bytes to the receive input
`timescale 1ns/100ps
module scrf_card_model (
  input  wire logic       sys_clk,
  output logic            rx_done,
  output logic            rx_perr,
  output logic [7:0]      rx_data
);
  logic       done_r = 1'b0;
  logic       perr_r = 1'b0;
  logic [7:0] data_r = 8'h00;
  // inverted outside the pulse, so a design that samples late sees garbage
  assign rx_done = done_r;
  assign rx_perr = done_r ? perr_r : ~perr_r;
  assign rx_data = done_r ? data_r : ~data_r;

  task send(input logic [7:0] d, input logic p);
    @(posedge sys_clk);
    data_r <= d;
    perr_r <= p;
    done_r <= 1'b1;
    @(posedge sys_clk);
    done_r <= 1'b0;
  endtask
endmodule // scrf_card_model

// file: sim/tb_top.sv
// self-checking bench for the receive-full flag block
`timescale 1ns/100ps
`include "scrf_params.svh"
module tb_top;
  logic                    sys_clk = 1'b0;
  logic                    srst    = 1'b1;
  logic [`SCRF_ADDR_W-1:0] addr    = 4'h0;
  logic [31:0]             wdata   = 32'h0;
  logic                    wr      = 1'b0;
  logic                    rd      = 1'b0;
  logic                    rd_d    = 1'b0;
  logic [31:0]             rdata;
  logic                    rx_done, rx_perr, flag;
  logic [7:0]              rx_data, hold, b;
  logic [63:0]             exp_q[$];
  logic [63:0]             e;
  int                      errors = 0;
  int                      n_compared = 0;

  always #4 sys_clk = ~sys_clk;

  scrf_top scrf_top_i (.sys_clk(sys_clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_done(rx_done),
    .rx_perr(rx_perr), .rx_data(rx_data), .receive_full_flag(flag),
    .receive_holding_register(hold));
  scrf_card_model scrf_card_model_i (.sys_clk(sys_clk), .rx_done(rx_done),
    .rx_perr(rx_perr), .rx_data(rx_data));

  ////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask
  // expectation noted as {mask, value}
  task rd_reg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
    exp_q.push_back({m, x});
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
  endtask
  task stat(input logic f);
    rd_reg(`SCRF_OFS_STATUS, 32'h40, {25'h0, f, 6'h0});
  endtask
  task hd(input logic [7:0] x);
    rd_reg(`SCRF_OFS_HOLD, 32'hFF, {24'h0, x});
  endtask

  // read data stands only in the cycle after the strobe; the level outputs
  // are looked at in that same cycle
  always @(posedge sys_clk) begin
    rd_d <= rd;
    if (rd_d) begin
      e = exp_q.pop_front();
      check(rdata & e[63:32], e[31:0]);
      if (e[63:32] == 32'h0000_0040) begin
        check({25'h0, flag, 6'h0}, e[31:0]);
      end
      if (e[63:32] == 32'h0000_00FF) begin
        check({24'h0, hold}, e[31:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h6403));
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    stat(1'b0);
    hd(8'h00);
    rd_reg(4'hC, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      wr_reg(`SCRF_OFS_CTRL, 32'h1);
      rd_reg(`SCRF_OFS_CTRL, 32'h3, 32'h1);
      scrf_card_model_i.send(b, 1'b0);
      stat(1'b1);
      wr_reg(`SCRF_OFS_STATUS, $urandom | 32'h40);
      stat(1'b1);
      // char parity error while the flag is set
      scrf_card_model_i.send(~b, 1'b1);
      stat(1'b1);
      hd(b);
      stat(1'b0);
      wr_reg(`SCRF_OFS_STATUS, $urandom | 32'h40);
      stat(1'b0);
      scrf_card_model_i.send(b, 1'b0);
      wr_reg(`SCRF_OFS_STATUS, $urandom & ~32'h40);
      stat(1'b0);
      hd(b);
      scrf_card_model_i.send(~b, 1'b1);
      stat(1'b0);
      hd(b);
      wr_reg(`SCRF_OFS_CTRL, 32'h3);
      rd_reg(`SCRF_OFS_CTRL, 32'h3, 32'h3);
      scrf_card_model_i.send(b ^ 8'h5A, 1'b1);
      stat(1'b1);
      hd(b ^ 8'h5A);
      stat(1'b0);
      // receiver off, once with the flag set and once with it clear
      scrf_card_model_i.send(b, 1'b0);
      wr_reg(`SCRF_OFS_CTRL, 32'h2);
      scrf_card_model_i.send(~b, 1'b0);
      stat(1'b1);
      hd(b);
      scrf_card_model_i.send(b ^ 8'h5A, 1'b0);
      stat(1'b0);
      hd(b);
    end
    // reset in mid-run with the flag set
    wr_reg(`SCRF_OFS_CTRL, 32'h1);
    scrf_card_model_i.send(8'hA5, 1'b0);
    stat(1'b1);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    stat(1'b0);
    hd(8'h00);
    rd_reg(`SCRF_OFS_CTRL, 32'h3, 32'h0);
    repeat (2) @(posedge sys_clk);
    close_out();
  end

  initial begin
    #(8 * 4000);
    errors++;
    close_out();
  end
endmodule // tb_top
